// file: acrs_pkg.sv
// Purpose: Shared constants and carriers for the converter config slice.
// Assumes: AXI4-Lite with 32-bit data, registers one aligned word each.
// Notes:   Paged map folded into one flat byte address space.
package acrs_pkg;

    // ==========================================================
    // Address map
    // ==========================================================
    localparam logic [15:0] ACRS_PAGE_MASTER  = 16'h0080;
    localparam logic [15:0] ACRS_PAGE_CONV    = 16'h000F;
    localparam logic [15:0] ACRS_PAGE_DIGITAL = 16'h6800;
    localparam logic [7:0]  ACRS_OFF_APPLY    = 8'h00;
    localparam logic [7:0]  ACRS_OFF_DECFILT  = 8'h41;
    localparam logic [7:0]  ACRS_OFF_DECEN    = 8'h4D;
    localparam logic [7:0]  ACRS_OFF_PERF_LO  = 8'h39;
    localparam logic [7:0]  ACRS_OFF_PERF_MID = 8'h3A;
    localparam logic [7:0]  ACRS_OFF_PWRDN    = 8'h55;
    localparam logic [7:0]  ACRS_OFF_PERF_HI  = 8'h56;
    localparam logic [7:0]  ACRS_OFF_ROUTE    = 8'h59;
    localparam logic [7:0]  ACRS_OFF_THRESH   = 8'h5F;
    // Byte address = page window base + 4 * offset.
    localparam logic [11:0] ACRS_WIN_MASTER   = 12'h000;
    localparam logic [11:0] ACRS_WIN_CONV     = 12'h400;
    localparam logic [11:0] ACRS_WIN_DIGITAL  = 12'h800;
    localparam logic [11:0] ACRS_WIN_IRQ      = 12'hC00;
    localparam logic [7:0]  ACRS_OFF_IRQ_STAT = 8'h00;
    localparam logic [7:0]  ACRS_OFF_IRQ_MASK = 8'h01;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int ACRS_BIT_PWRDN      = 4;
    localparam int ACRS_BIT_MASKSEL    = 5;
    localparam int ACRS_BIT_PERF3      = 2;
    localparam int ACRS_BIT_PERF2      = 6;
    localparam int ACRS_BIT_ROUTE      = 7;
    localparam int ACRS_BIT_ALWAYS1    = 5;
    localparam int ACRS_BIT_APPLY      = 0;
    localparam int ACRS_BIT_FILT_EXT   = 4;
    localparam int ACRS_BIT_DECEN      = 3;
    localparam logic [7:0] ACRS_RST_THRESH  = 8'hE3;
    localparam logic [2:0] ACRS_RST_FILT_LO = 3'h2;
    localparam logic [3:0] ACRS_CODE_LOWPASS  = 4'hA;
    localparam logic [3:0] ACRS_CODE_HIGHPASS = 4'hE;
    localparam int ACRS_NUM_IRQ = 3;
    localparam int ACRS_IRQ_APPLY  = 0;
    localparam int ACRS_IRQ_BADSEL = 1;
    localparam int ACRS_IRQ_PWRDN  = 2;
    localparam logic [1:0] ACRS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ACRS_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ACRS_FILT_LOWPASS,
        ACRS_FILT_HIGHPASS,
        ACRS_FILT_UNUSED
    } acrs_filt_t;

    // Settings that steer the converter core.
    typedef struct packed {
        logic       power_down;
        logic       power_down_mask_choice;
        logic [3:0] performance_setting;
        logic       overrange_b_to_readback;
        logic [7:0] overrange_threshold;
        acrs_filt_t filter_mode;
    } acrs_cfg_t;

    // One register access decoded off the bus.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
    } acrs_acc_t;
endpackage

// file: acrs_axil.sv
// Purpose: AXI4-Lite slave front end that yields up to one write and one read per cycle, both on araddr when together.
// Assumes: One write and one read outstanding at most.
// Notes:   Write response one cycle after both address and data held.
`timescale 1ns/100ps
module acrs_axil
    import acrs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output acrs_acc_t        acc,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_hit,
    input  wire logic        wr_hit
);
    typedef struct packed {
        logic        aw_full;
        logic [11:0] aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } acrs_axil_st_t;

    acrs_axil_st_t st_r;
    acrs_axil_st_t st_nxt;
    logic          do_wr;
    logic          do_rd;

    // ==========================================================
    // Handshakes
    // ==========================================================
    assign awready = !st_r.aw_full && !st_r.bvalid;
    assign wready  = !st_r.w_full && !st_r.bvalid;
    assign arready = !st_r.rvalid;
    assign bvalid  = st_r.bvalid;
    assign bresp   = st_r.bresp;
    assign rvalid  = st_r.rvalid;
    assign rresp   = st_r.rresp;
    assign rdata   = st_r.rdata;
    assign do_wr   = st_r.aw_full && st_r.w_full;
    assign do_rd   = arvalid && arready;

    always_comb begin
        acc       = '0;
        acc.wr    = do_wr;
        acc.rd    = do_rd;
        acc.addr  = do_rd ? araddr : st_r.aw_addr;
        acc.wdata = st_r.w_data;
        acc.wstrb = st_r.w_strb;
    end

    always_comb begin
        st_nxt = st_r;
        if (awvalid && awready) begin
            st_nxt.aw_full = 1'b1;
            st_nxt.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            st_nxt.w_full = 1'b1;
            st_nxt.w_data = wdata;
            st_nxt.w_strb = wstrb;
        end
        if (do_wr) begin
            st_nxt.aw_full = 1'b0;
            st_nxt.w_full  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = wr_hit ? ACRS_RESP_OKAY : ACRS_RESP_SLVERR;
        end else if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (do_rd) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_data;
            st_nxt.rresp  = rd_hit ? ACRS_RESP_OKAY : ACRS_RESP_SLVERR;
        end else if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// file: acrs_apply.sv
// Purpose: Detects the apply pulse on the digital page strobe bit.
// Assumes: The strobe bit is the stored register value.
// Notes:   A pulse is a rising edge followed by a falling edge.
`timescale 1ns/100ps
module acrs_apply
    import acrs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic strobe_bit,
    output logic      apply
);
    typedef struct packed {
        logic prev;
        logic armed;
        logic apply;
    } acrs_apply_st_t;

    acrs_apply_st_t st_r;
    acrs_apply_st_t st_nxt;

    assign apply = st_r.apply;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.prev  = strobe_bit;
        st_nxt.apply = 1'b0;
        if (strobe_bit && !st_r.prev) begin
            st_nxt.armed = 1'b1;
        end
        // Completing the 0-1-0 sequence commits the staged settings.
        if (!strobe_bit && st_r.prev && st_r.armed) begin
            st_nxt.armed = 1'b0;
            st_nxt.apply = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// file: acrs_top.sv
// How it works
// - Master register_power_down bit 4 is a read/write power-down bit, 0 normal.
// - With power-down at 1 the blocks of the selected mask are powered down.
// - A master bit picks mask one at 0 and mask two at 1.
// - Performance bit 3 is write-only at bit 2 of 56h; others at 39h, 3Ah.
// - Write-only bit 7 of 59h routes the B overrange flag to readback pin.
// - Registers 55h, 56h and 59h live in the master page 080h.
// - The converter page holds one shared threshold resetting to E3h.
// - That threshold sits at offset 5F of page 0Fh.
// - Digital page settings take effect only once apply bit 0 pulses.
// - Digital decimation_filter_select holds the filter code, low bits reset to 2h.
// - The filter code governs only when enable bit 3 of 4Dh is set.
// - Enable 0 gives low-pass; enable 1 with 1010 low, 1110 high-pass.
// Purpose: Configuration register slice of a dual-channel converter.
// Assumes: AXI4-Lite master with at most one write and one read in flight.
// Notes:   Write-only fields read back as zero.
`timescale 1ns/100ps
module acrs_top
    import acrs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        fast_overrange_flag_b,
    input  wire logic        readback_normal,
    output logic             serial_readback_pin,
    output logic             block_power_down,
    output logic             power_down_mask_choice,
    output logic [3:0]       performance_setting,
    output logic [7:0]       overrange_threshold,
    output acrs_filt_t       filter_mode,
    output logic             irq
);
    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic       pwrdn;
        logic       mask_sel;
        logic [1:0] perf_lo;
        logic       perf_mid;
        logic       perf_hi;
        logic       route_b;
        logic       always1;
        logic [7:0] thresh;
        logic       apply_bit;
        logic [3:0] filt_stage;
        logic       decen_stage;
        logic [3:0] filt_live;
        logic       decen_live;
        logic [1:0] fast_overrange_flag_sync;
        logic [1:0] rbk_sync;
        logic       pin;
        acrs_filt_t mode;
        logic       pwrdn_prev;
        logic [ACRS_NUM_IRQ-1:0] stat;
        logic [ACRS_NUM_IRQ-1:0] mask;
        logic       irq;
    } acrs_st_t;

    acrs_st_t    st_r;
    acrs_st_t    st_nxt;
    acrs_acc_t   acc;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic        wr_hit;
    logic        apply;
    logic [ACRS_NUM_IRQ-1:0] ev;

    // Page window and offset to the register's byte address.
    function automatic logic [11:0] reg_addr(input logic [11:0] win,
                                             input logic [7:0]  off);
        reg_addr = win + {2'h0, off, 2'h0};
    endfunction

    function automatic logic is_reg(input logic [11:0] a,
                                    input logic [11:0] win,
                                    input logic [7:0]  off);
        is_reg = (a[11:2] == reg_addr(win, off)[11:2]);
    endfunction

    function automatic acrs_filt_t filt_decode(input logic       en,
                                               input logic [3:0] code);
        if (!en) begin
            filt_decode = ACRS_FILT_LOWPASS;
        end else if (code == ACRS_CODE_LOWPASS) begin
            filt_decode = ACRS_FILT_LOWPASS;
        end else if (code == ACRS_CODE_HIGHPASS) begin
            filt_decode = ACRS_FILT_HIGHPASS;
        end else begin
            filt_decode = ACRS_FILT_UNUSED;
        end
    endfunction

    acrs_axil u_axil (
        .clk     (clk),
        .rst_n   (rst_n),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .acc     (acc),
        .rd_data (rd_data),
        .rd_hit  (rd_hit),
        .wr_hit  (wr_hit)
    );

    acrs_apply u_apply (
        .clk        (clk),
        .rst_n      (rst_n),
        .strobe_bit (st_r.apply_bit),
        .apply      (apply)
    );

    // ==========================================================
    // Read decode
    // ==========================================================
    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        if (is_reg(acc.addr, ACRS_WIN_MASTER, ACRS_OFF_PWRDN)) begin
            rd_data[ACRS_BIT_PWRDN]   = st_r.pwrdn;
            rd_data[ACRS_BIT_MASKSEL] = st_r.mask_sel;
        end else if (is_reg(acc.addr, ACRS_WIN_MASTER,
                            ACRS_OFF_PERF_LO)) begin
            rd_data[7:6] = st_r.perf_lo;
        end else if (is_reg(acc.addr, ACRS_WIN_MASTER,
                            ACRS_OFF_PERF_MID)) begin
            rd_data[ACRS_BIT_PERF2] = st_r.perf_mid;
        end else if (is_reg(acc.addr, ACRS_WIN_MASTER,
                            ACRS_OFF_PERF_HI)) begin
            rd_data = '0;
        end else if (is_reg(acc.addr, ACRS_WIN_MASTER,
                            ACRS_OFF_ROUTE)) begin
            rd_data[ACRS_BIT_ALWAYS1] = st_r.always1;
        end else if (is_reg(acc.addr, ACRS_WIN_CONV,
                            ACRS_OFF_THRESH)) begin
            rd_data[7:0] = st_r.thresh;
        end else if (is_reg(acc.addr, ACRS_WIN_DIGITAL,
                            ACRS_OFF_APPLY)) begin
            rd_data[ACRS_BIT_APPLY] = st_r.apply_bit;
        end else if (is_reg(acc.addr, ACRS_WIN_DIGITAL,
                            ACRS_OFF_DECFILT)) begin
            rd_data[ACRS_BIT_FILT_EXT] = st_r.filt_stage[3];
            rd_data[2:0]               = st_r.filt_stage[2:0];
        end else if (is_reg(acc.addr, ACRS_WIN_DIGITAL,
                            ACRS_OFF_DECEN)) begin
            rd_data[ACRS_BIT_DECEN] = st_r.decen_stage;
        end else if (is_reg(acc.addr, ACRS_WIN_IRQ,
                            ACRS_OFF_IRQ_STAT)) begin
            rd_data[ACRS_NUM_IRQ-1:0] = st_r.stat;
        end else if (is_reg(acc.addr, ACRS_WIN_IRQ,
                            ACRS_OFF_IRQ_MASK)) begin
            rd_data[ACRS_NUM_IRQ-1:0] = st_r.mask;
        end else begin
            rd_hit = 1'b0;
        end
    end
    // Every readable address is also writable.
    assign wr_hit = rd_hit;

    // ==========================================================
    // Events
    // ==========================================================
    always_comb begin
        ev                  = '0;
        ev[ACRS_IRQ_APPLY]  = apply;
        ev[ACRS_IRQ_BADSEL] = apply && (filt_decode(st_r.decen_stage,
                              st_r.filt_stage) == ACRS_FILT_UNUSED);
        ev[ACRS_IRQ_PWRDN]  = st_r.pwrdn && !st_r.pwrdn_prev;
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic b0;
        b0     = acc.wr && acc.wstrb[0];
        st_nxt = st_r;
        if (b0 && is_reg(acc.addr, ACRS_WIN_MASTER, ACRS_OFF_PWRDN)) begin
            st_nxt.pwrdn    = acc.wdata[ACRS_BIT_PWRDN];
            st_nxt.mask_sel = acc.wdata[ACRS_BIT_MASKSEL];
        end
        if (b0 && is_reg(acc.addr, ACRS_WIN_MASTER, ACRS_OFF_PERF_LO)) begin
            st_nxt.perf_lo = acc.wdata[7:6];
        end
        if (b0 && is_reg(acc.addr, ACRS_WIN_MASTER,
                         ACRS_OFF_PERF_MID)) begin
            st_nxt.perf_mid = acc.wdata[ACRS_BIT_PERF2];
        end
        if (b0 && is_reg(acc.addr, ACRS_WIN_MASTER, ACRS_OFF_PERF_HI)) begin
            st_nxt.perf_hi = acc.wdata[ACRS_BIT_PERF3];
        end
        if (b0 && is_reg(acc.addr, ACRS_WIN_MASTER, ACRS_OFF_ROUTE)) begin
            st_nxt.route_b = acc.wdata[ACRS_BIT_ROUTE];
            st_nxt.always1 = acc.wdata[ACRS_BIT_ALWAYS1];
        end
        if (b0 && is_reg(acc.addr, ACRS_WIN_CONV, ACRS_OFF_THRESH)) begin
            st_nxt.thresh = acc.wdata[7:0];
        end
        if (b0 && is_reg(acc.addr, ACRS_WIN_DIGITAL, ACRS_OFF_APPLY)) begin
            st_nxt.apply_bit = acc.wdata[ACRS_BIT_APPLY];
        end
        if (b0 && is_reg(acc.addr, ACRS_WIN_DIGITAL,
                         ACRS_OFF_DECFILT)) begin
            st_nxt.filt_stage = {acc.wdata[ACRS_BIT_FILT_EXT],
                                 acc.wdata[2:0]};
        end
        if (b0 && is_reg(acc.addr, ACRS_WIN_DIGITAL, ACRS_OFF_DECEN)) begin
            st_nxt.decen_stage = acc.wdata[ACRS_BIT_DECEN];
        end
        // Staged digital settings only reach the filter on apply.
        if (apply) begin
            st_nxt.filt_live  = st_r.filt_stage;
            st_nxt.decen_live = st_r.decen_stage;
        end
        st_nxt.mode = filt_decode(st_r.decen_live,
                                  st_r.filt_live);
        // Pin inputs come from outside the clock domain.
        st_nxt.fast_overrange_flag_sync = {st_r.fast_overrange_flag_sync[0], fast_overrange_flag_b};
        st_nxt.rbk_sync  = {st_r.rbk_sync[0], readback_normal};
        st_nxt.pin = st_r.route_b ? st_r.fast_overrange_flag_sync[1]
                                  : st_r.rbk_sync[1];
        st_nxt.pwrdn_prev = st_r.pwrdn;
        // Set wins over a write-one clear in the same cycle.
        if (b0 && is_reg(acc.addr, ACRS_WIN_IRQ, ACRS_OFF_IRQ_STAT)) begin
            st_nxt.stat = st_r.stat & ~acc.wdata[ACRS_NUM_IRQ-1:0];
        end
        if (b0 && is_reg(acc.addr, ACRS_WIN_IRQ, ACRS_OFF_IRQ_MASK)) begin
            st_nxt.mask = acc.wdata[ACRS_NUM_IRQ-1:0];
        end
        st_nxt.stat = st_nxt.stat | ev;
        st_nxt.irq  = |(st_r.stat & st_r.mask);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r            <= '0;
            st_r.thresh     <= ACRS_RST_THRESH;
            st_r.filt_stage <= {1'b0, ACRS_RST_FILT_LO};
            st_r.filt_live  <= {1'b0, ACRS_RST_FILT_LO};
            st_r.mode       <= ACRS_FILT_LOWPASS;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign serial_readback_pin    = st_r.pin;
    assign block_power_down       = st_r.pwrdn;
    assign power_down_mask_choice = st_r.mask_sel;
    assign performance_setting    = {st_r.perf_hi, st_r.perf_mid,
                                     st_r.perf_lo};
    assign overrange_threshold    = st_r.thresh;
    assign filter_mode            = st_r.mode;
    assign irq                    = st_r.irq;
endmodule

// file: acrs_props.sv
// Purpose: Bus timing and config update checks for the config slice.
// Assumes: Sees only top-level ports.
// Notes:   Latencies follow the bus front end of the slice.
`timescale 1ns/100ps
module acrs_props
    import acrs_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       block_power_down,
    input wire logic       power_down_mask_choice,
    input wire logic [3:0] performance_setting,
    input wire logic [7:0] overrange_threshold,
    input wire acrs_filt_t filter_mode
);
    // ==========================================================
    // Checks
    // ==========================================================
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_thresh_reset: assert property ($rose(rst_n) |->
        overrange_threshold == 8'hE3 && !block_power_down)
        else $error("reset values wrong");
    a_cfg_on_commit: assert property (!$stable({block_power_down,
        power_down_mask_choice, performance_setting,
        overrange_threshold}) |-> $rose(s_axi_bvalid))
        else $error("config changed without a write");
    a_filt_after_apply: assert property (!$stable(filter_mode) |->
        $past(s_axi_bvalid, 2)) else $error("filter changed off apply");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
        else $error("late write answer");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |-> ##[1:2] s_axi_rvalid) else $error("late read answer");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped early");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && !s_axi_arready) else $error("rvalid dropped");
    a_ready_drop: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("ready while busy");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($rose(block_power_down));
    cover property (filter_mode == ACRS_FILT_HIGHPASS);
endmodule
bind acrs_top acrs_props i_acrs_props (.*);

// file: tb.sv
// Purpose: Directed register and output checks for the config slice.
// Assumes: One bus access at a time; answers waited for up to 40 cycles.
// Notes:   Write-only fields are seen through the outputs alone.
`timescale 1ns/100ps
module tb
    import acrs_pkg::*;
;
    localparam logic [1:0] OK = ACRS_RESP_OKAY;
    logic        clk = 1'b0, rst_n = 1'b0, irq;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1, performance_setting;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, fast_overrange_flag_b = 1'b0;
    logic        readback_normal = 1'b0, serial_readback_pin;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic        block_power_down, power_down_mask_choice;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  overrange_threshold;
    acrs_filt_t  filter_mode, prev;
    int          mismatches = 0, total_checks = 0;
    logic [7:0]  codes[4] = '{8'h16, 8'h12, 8'h13, 8'h16};
    logic [7:0]  ens[4] = '{8'h08, 8'h08, 8'h08, 8'h00};
    acrs_filt_t  modes[4] = '{ACRS_FILT_HIGHPASS, ACRS_FILT_LOWPASS,
                              ACRS_FILT_UNUSED, ACRS_FILT_LOWPASS};

    acrs_top i_acrs_top (.*);
    always #5 clk = ~clk;

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // Ready is raised only after the answer shows, so the hold is exercised.
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        int n;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        mismatches += (n == 40);
        if (n == 40) wrap_up();
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input logic [1:0] er);
        int n;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        mismatches += (n == 40);
        if (n == 40) wrap_up();
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h0, e}, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // ==========================================================
    // Sequence
    // ==========================================================
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        chk("thr", 32'hE3, {24'h0, overrange_threshold});
        chk("filt", 32'h0, {30'h0, filter_mode});
        rd(12'h57C, 8'hE3, OK);
        rd(12'h904, 8'h02, OK);
        wr(12'h154, 8'h10, OK);
        chk("pd", 32'h1, {31'h0, block_power_down});
        chk("msel", 32'h0, {31'h0, power_down_mask_choice});
        rd(12'h154, 8'h10, OK);
        wr(12'h154, 8'h30, OK);
        chk("msel", 32'h1, {31'h0, power_down_mask_choice});
        wr(12'h0E4, 8'hC0, OK);
        wr(12'h0E8, 8'h40, OK);
        wr(12'h158, 8'h04, OK);
        chk("perf", 32'hF, {28'h0, performance_setting});
        rd(12'h158, 8'h00, OK);
        fast_overrange_flag_b <= 1'b1;
        wr(12'h164, 8'hA0, OK);
        repeat (4) @(posedge clk);
        chk("pin", 32'h1, {31'h0, serial_readback_pin});
        rd(12'h164, 8'h20, OK);
        fast_overrange_flag_b <= 1'b0;
        readback_normal       <= 1'b1;
        wr(12'h164, 8'h20, OK);
        repeat (4) @(posedge clk);
        chk("pin", 32'h1, {31'h0, serial_readback_pin});
        wr(12'h57C, 8'h5A, OK);
        rd(12'h57C, 8'h5A, OK);
        prev = ACRS_FILT_LOWPASS;
        for (int i = 0; i < 4; i++) begin
            wr(12'h904, codes[i], OK);
            wr(12'h934, ens[i], OK);
            chk("staged", {30'h0, prev}, {30'h0, filter_mode});
            wr(12'h800, 8'h01, OK);
            wr(12'h800, 8'h00, OK);
            repeat (3) @(posedge clk);
            chk("filt", {30'h0, modes[i]}, {30'h0, filter_mode});
            prev = modes[i];
        end
        rd(12'hC00, 8'h07, OK);
        chk("irq", 32'h0, {31'h0, irq});
        wr(12'hC04, 8'h07, OK);
        chk("irq", 32'h1, {31'h0, irq});
        wr(12'hC00, 8'h01, OK);
        rd(12'hC00, 8'h06, OK);
        wr(12'hC04, 8'h01, OK);
        chk("irq", 32'h0, {31'h0, irq});
        rd(12'hC08, 8'h00, ACRS_RESP_SLVERR);
        wr(12'hC08, 8'hFF, ACRS_RESP_SLVERR);
        wrap_up();
    end
endmodule
